// >>> design/iox_pkg.sv
package iox_pkg;
    localparam logic [4:0] IOX_ADDR_HI   = 5'h08;
    localparam logic [7:0] IOX_GC_ADDR   = 8'h00;
    localparam logic [7:0] IOX_GC_CMD    = 8'h06;
    localparam logic [7:0] IOX_ID_WR     = 8'hF8;
    localparam logic [7:0] IOX_ID_RD     = 8'hF9;
    localparam logic [6:0] IOX_PTR_RST   = 7'h00;
    localparam logic [6:0] IOX_LAST_REG  = 7'h6F;
    localparam logic [6:0] IOX_RSV_FIRST = 7'h14;
    localparam logic [6:0] IOX_RSV_NEXT  = 7'h30;
    localparam logic [6:0] IOX_RSV_HOLE  = 7'h39;
    localparam logic [6:0] IOX_DRV_LO    = 7'h30;
    localparam logic [6:0] IOX_DRV_HI    = 7'h38;
    localparam logic [6:0] IOX_EXT_LO    = 7'h3A;
    localparam logic [6:0] IOX_OCFG      = 7'h53;
    localparam logic [6:0] IOX_EDGE_LO   = 7'h54;
    localparam logic [6:0] IOX_EDGE_HI   = 7'h5C;
    localparam logic [6:0] IOX_TAIL_LO   = 7'h5D;
    localparam logic [6:0] IOX_GRP_SPAN  = 7'h05;
    localparam logic [7:0] IOX_MAP_BYTES = 8'h52;
    localparam logic [1:0] IOX_ID_LAST   = 2'h2;
    localparam logic [3:0] IOX_BITS      = 4'h8;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iox_reg_req_type;

    typedef enum logic [4:0] {
        IOX_IDLE = 5'b00001,
        IOX_RX   = 5'b00010,
        IOX_ACK  = 5'b00100,
        IOX_TX   = 5'b01000,
        IOX_RACK = 5'b10000
    } iox_state_type;

    typedef enum logic [5:0] {
        IOX_C_ADDR  = 6'b000001,
        IOX_C_PTR   = 6'b000010,
        IOX_C_DATA  = 6'b000100,
        IOX_C_GCCMD = 6'b001000,
        IOX_C_GCEXT = 6'b010000,
        IOX_C_IDSEL = 6'b100000
    } iox_ctx_type;
endpackage

// >>> design/iox_front_end.sv
module iox_front_end
    import iox_pkg::*;
#(
    parameter logic [11:0] MAKER_CODE = 12'h5A5, // Arbitrary value
    parameter logic [8:0]  PART_CODE  = 9'h0C3,  // Arbitrary value
    parameter logic [2:0]  REV_CODE   = 3'h1     // Arbitrary value
)
(
    input  wire logic            clk_i,
    input  wire logic            srst_i,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_o,
    input  wire logic            strap_select_high_bit_i,
    input  wire logic            strap_select_low_bit_i,
    output iox_reg_req_type      reg_req_o,
    input  wire logic [7:0]      reg_rdata_i,
    output logic                 soft_rst_o,
    output logic [7:0]           pointer_o
);
    iox_state_type   state;
    iox_ctx_type     ctx, next_ctx;
    logic            scl_q, sda_q, scl_rise, scl_fall, start, stop;
    logic [3:0]      bit_cnt;
    logic [7:0]      shift, tx_shift, tx_byte, step_cnt, wdata_q;
    logic            tx_mode, tx_id, take, go_tx, go_id, own;
    logic            byte_done, tx_done, load, wr_q, rd_q;
    logic [23:0]     id_word;
    logic [6:0]      ptr, ptr_start;
    logic            sequential_step_flag, id_armed, gc_armed;
    logic [1:0]      id_idx;

    function automatic logic [6:0] iox_step(input logic [6:0] p, input logic ai, input logic wrap,
                                            input logic [6:0] st);
        logic [6:0] b, l, n;
        b = p;
        l = p;
        n = 7'(p + 7'h01);
        if (ai)
        begin
            if (wrap)
                n = st;
            else if (p >= IOX_LAST_REG)
                n = IOX_PTR_RST;
            else if (n == IOX_RSV_FIRST)
                n = IOX_RSV_NEXT;
            else if (n == IOX_RSV_HOLE)
                n = IOX_EXT_LO;
        end
        else
        begin
            if (p < IOX_RSV_FIRST)
                b = 7'((p / IOX_GRP_SPAN) * IOX_GRP_SPAN);
            else if (p <= IOX_DRV_HI)
            begin
                b = IOX_DRV_LO;
                l = IOX_DRV_HI;
            end
            else if (p == IOX_OCFG)
                b = IOX_OCFG;
            else if (p >= IOX_EDGE_LO && p <= IOX_EDGE_HI)
            begin
                b = IOX_EDGE_LO;
                l = IOX_EDGE_HI;
            end
            else if (p < IOX_OCFG)
                b = 7'(IOX_EXT_LO + ((p - IOX_EXT_LO) / IOX_GRP_SPAN) * IOX_GRP_SPAN);
            else
                b = 7'(IOX_TAIL_LO + ((p - IOX_TAIL_LO) / IOX_GRP_SPAN) * IOX_GRP_SPAN);
            if (p != IOX_OCFG && !(p >= IOX_DRV_LO && p <= IOX_DRV_HI)
                && !(p >= IOX_EDGE_LO && p <= IOX_EDGE_HI))
                l = (7'(b + 7'h04) > IOX_LAST_REG) ? IOX_LAST_REG : 7'(b + 7'h04);
            n = (p >= l) ? b : 7'(p + 7'h01);
        end
        return n;
    endfunction

    // Inputs are already synchronous, so one stage of history gives the edges
    assign scl_rise  = scl_i && !scl_q;
    assign scl_fall  = !scl_i && scl_q;
    assign start     = scl_i && scl_q && sda_q && !sda_i;
    assign stop      = scl_i && scl_q && !sda_q && sda_i;
    assign byte_done = (state == IOX_RX) && scl_fall && (bit_cnt == IOX_BITS);
    assign tx_done   = (state == IOX_TX) && scl_fall && (bit_cnt == IOX_BITS);
    assign load      = (state == IOX_ACK) && scl_fall && tx_mode;
    assign own       = (shift[7:1] == {IOX_ADDR_HI, strap_select_high_bit_i, strap_select_low_bit_i});
    assign id_word   = {MAKER_CODE, PART_CODE, REV_CODE};
    assign tx_byte   = !tx_id ? reg_rdata_i :
                       (id_idx == 2'h0) ? id_word[23:16] :
                       (id_idx == 2'h1) ? id_word[15:8] : id_word[7:0];
    assign sda_o     = 1'b0;
    assign reg_req_o = '{addr: ptr, wdata: wdata_q, wr: wr_q, rd: rd_q};
    assign pointer_o = {sequential_step_flag, ptr};

    always_comb
    begin
        take     = 1'b0;
        go_tx    = 1'b0;
        go_id    = 1'b0;
        next_ctx = ctx;
        case (ctx)
            IOX_C_ADDR:
            begin
                if (own)
                begin
                    take     = 1'b1;
                    go_tx    = shift[0];
                    next_ctx = IOX_C_PTR;
                end
                else if (shift == IOX_GC_ADDR)
                begin
                    take     = 1'b1;
                    next_ctx = IOX_C_GCCMD;
                end
                else if (shift == IOX_ID_WR)
                begin
                    take     = 1'b1;
                    next_ctx = IOX_C_IDSEL;
                end
                else if (shift == IOX_ID_RD && id_armed)
                begin
                    take  = 1'b1;
                    go_tx = 1'b1;
                    go_id = 1'b1;
                end
            end
            IOX_C_PTR:
            begin
                take     = 1'b1;
                next_ctx = IOX_C_DATA;
            end
            IOX_C_DATA:
                take = 1'b1;
            IOX_C_GCCMD:
            begin
                take     = (shift == IOX_GC_CMD);
                next_ctx = IOX_C_GCEXT;
            end
            IOX_C_GCEXT:
                take = 1'b0;
            IOX_C_IDSEL:
                take = own;
            default:
                take = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state    <= IOX_IDLE;
            ctx      <= IOX_C_ADDR;
            bit_cnt  <= 4'h0;
            shift    <= 8'h00;
            tx_shift <= 8'h00;
            tx_mode  <= 1'b0;
            tx_id    <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else if (start)
        begin
            state    <= IOX_RX;
            ctx      <= IOX_C_ADDR;
            bit_cnt  <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop)
        begin
            state    <= IOX_IDLE;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            case (state)
                IOX_RX:
                begin
                    if (scl_rise)
                    begin
                        shift   <= {shift[6:0], sda_i};
                        bit_cnt <= 4'(bit_cnt + 4'h1);
                    end
                    else if (byte_done)
                    begin
                        // Refused bytes park the machine until the next START
                        state    <= take ? IOX_ACK : IOX_IDLE;
                        sda_oe_o <= take;
                        ctx      <= next_ctx;
                        tx_mode  <= go_tx;
                        tx_id    <= go_id;
                    end
                end
                IOX_ACK:
                begin
                    if (scl_fall)
                    begin
                        state    <= tx_mode ? IOX_TX : IOX_RX;
                        sda_oe_o <= tx_mode && !tx_byte[7];
                        tx_shift <= {tx_byte[6:0], 1'b0};
                        bit_cnt  <= tx_mode ? 4'h1 : 4'h0;
                    end
                end
                IOX_TX:
                begin
                    if (scl_fall)
                    begin
                        state    <= (bit_cnt == IOX_BITS) ? IOX_RACK : IOX_TX;
                        sda_oe_o <= (bit_cnt != IOX_BITS) && !tx_shift[7];
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        bit_cnt  <= 4'(bit_cnt + 4'h1);
                    end
                end
                IOX_RACK:
                begin
                    if (scl_rise)
                        state <= sda_i ? IOX_IDLE : IOX_ACK;
                end
                IOX_IDLE:
                    sda_oe_o <= 1'b0;
                default:
                    state <= IOX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || soft_rst_o)
        begin
            ptr                  <= IOX_PTR_RST;
            ptr_start            <= IOX_PTR_RST;
            sequential_step_flag <= 1'b0;
            step_cnt             <= 8'h00;
        end
        else if (byte_done && ctx == IOX_C_PTR)
        begin
            ptr                  <= shift[6:0];
            ptr_start            <= shift[6:0];
            sequential_step_flag <= shift[7];
            step_cnt             <= 8'h00;
        end
        else if (wr_q || tx_done && !tx_id)
        begin
            // Only srst_i or a STOP after an accepted general call reset clears the pointer; otherwise it rests one step past the last access
            ptr      <= iox_step(ptr, sequential_step_flag,
                                 step_cnt == 8'(IOX_MAP_BYTES - 8'h01), ptr_start);
            step_cnt <= (step_cnt == 8'(IOX_MAP_BYTES - 8'h01)) ? 8'h00 : 8'(step_cnt + 8'h01);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            wr_q    <= 1'b0;
            rd_q    <= 1'b0;
            wdata_q <= 8'h00;
        end
        else
        begin
            wr_q <= byte_done && take && ctx == IOX_C_DATA;
            rd_q <= load && !tx_id;
            if (byte_done && ctx == IOX_C_DATA)
                wdata_q <= shift;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || soft_rst_o)
            gc_armed <= 1'b0;
        else if (start || stop)
            gc_armed <= 1'b0;
        else if (byte_done && ctx == IOX_C_GCCMD)
            gc_armed <= take;
        else if (byte_done && ctx == IOX_C_GCEXT)
            gc_armed <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            soft_rst_o <= 1'b0;
        else
            soft_rst_o <= stop && gc_armed;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i || soft_rst_o || stop)
            id_armed <= 1'b0;
        else if (byte_done && ctx == IOX_C_IDSEL)
            id_armed <= own;
        else if (byte_done && ctx == IOX_C_ADDR && shift != IOX_ID_RD)
            id_armed <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            id_idx <= 2'h0;
        else if (byte_done && go_id)
            id_idx <= 2'h0;
        else if (tx_done && tx_id)
            id_idx <= (id_idx == IOX_ID_LAST) ? 2'h0 : 2'(id_idx + 2'h1);
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_gc_read_nack: assert property (byte_done && ctx == IOX_C_ADDR && shift == 8'h01
        |=> state == IOX_IDLE && !sda_oe_o) else $error("general call read was acknowledged");
    a_gc_cmd_ack: assert property (byte_done && ctx == IOX_C_GCCMD
        |=> sda_oe_o == ($past(shift) == 8'h06)) else $error("command byte answer wrong");
    a_gc_extra: assert property (byte_done && ctx == IOX_C_GCEXT
        |=> !sda_oe_o ##1 !gc_armed) else $error("extra general call byte acknowledged");
    a_soft_reset: assert property (stop && gc_armed
        |=> soft_rst_o ##1 ptr == 7'h00 && !sequential_step_flag) else $error("soft reset missing");
    a_rstart_cancel: assert property (start
        |=> !gc_armed ##1 !soft_rst_o) else $error("reset survived repeated start");
    a_id_stop: assert property (stop |=> !id_armed) else $error("identity kept across stop");
    a_id_wrap: assert property (tx_done && tx_id && id_idx == 2'h2
        |=> id_idx == 2'h0) else $error("identity did not wrap");
    a_ptr_load: assert property (byte_done && ctx == IOX_C_PTR && !soft_rst_o
        |=> ptr == $past(shift[6:0]) && sequential_step_flag == $past(shift[7]))
        else $error("pointer not stored");
    a_nack_idle: assert property (state == IOX_RACK && scl_rise && sda_i && !start && !stop
        |=> state == IOX_IDLE) else $error("refusal did not end read");
    a_ocfg_fixed: assert property (wr_q && !sequential_step_flag && ptr == 7'h53 && !soft_rst_o
        |=> ptr == 7'h53) else $error("pointer left fixed location");
endmodule

// >>> verification/iox_master.sv
module iox_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // SDA moves one clock after SCL falls, so the slave never sees it change at an edge
    task automatic bit_x(input logic b, output logic s);
        tick(1);
        sda_low_o = ~b;
        tick(3);
        scl_o = 1'b1;
        tick(2);
        s = sda_i;
        tick(2);
        scl_o = 1'b0;
    endtask

    task automatic start();
        tick(1);
        sda_low_o = 1'b0;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        tick(1);
        sda_low_o = 1'b1;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_low_o = 1'b0;
        tick(4);
    endtask

    // Address bytes carry the direction in bit 0
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], s);
        bit_x(1'b1, s);
        ack = ~s;
    endtask

    // Released SDA floats to the pull-up level on the slave's 1 bits
    task automatic rbyte(input logic give_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(~give_ack, s);
    endtask
endmodule

// >>> verification/iox_front_end_bench.sv
module iox_front_end_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import iox_pkg::*;

    localparam logic [11:0] MAKER = 12'hA3C; // Arbitrary value
    localparam logic [8:0]  PART  = 9'h1B6;  // Arbitrary value
    localparam logic [2:0]  REV   = 3'h5;    // Arbitrary value
    localparam logic [7:0]  DEV_W = 8'h44;

    logic            clk_i;
    logic            srst_i;
    logic            scl;
    logic            sda_low;
    logic            sda_w;
    logic            sda_o;
    logic            sda_oe;
    logic            soft_rst;
    logic [7:0]      ptr;
    logic [7:0]      rdata;
    iox_reg_req_type req;
    int              n_mismatch;
    int              cmp_count;
    int              n_soft;
    int              n_rd;
    logic            strap_hi;
    logic            strap_lo;
    logic [6:0]      wq[$];
    logic [7:0]      wdq[$];
    logic [23:0]     idw;
    logic [7:0]      tp[4];
    logic [6:0]      te[4][3];
    logic [7:0]      d;
    logic [7:0]      k;

    assign sda_w = ~sda_low & (sda_oe ? sda_o : 1'b1);
    assign rdata = {1'b0, req.addr} ^ 8'h5A;
    assign idw   = {MAKER, PART, REV};

    iox_front_end #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REV_CODE(REV)) i_dut (
        .clk_i                  (clk_i),
        .srst_i                 (srst_i),
        .scl_i                  (scl),
        .sda_i                  (sda_w),
        .sda_o                  (sda_o),
        .sda_oe_o               (sda_oe),
        .strap_select_high_bit_i(strap_hi),
        .strap_select_low_bit_i (strap_lo),
        .reg_req_o              (req),
        .reg_rdata_i            (rdata),
        .soft_rst_o             (soft_rst),
        .pointer_o              (ptr)
    );

    iox_master i_master (
        .clk_i    (clk_i),
        .sda_i    (sda_w),
        .scl_o    (scl),
        .sda_low_o(sda_low)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        if (req.wr === 1'b1)
        begin
            wq.push_back(req.addr);
            wdq.push_back(req.wdata);
        end
        if (req.rd === 1'b1)
            n_rd++;
        if (soft_rst === 1'b1)
            n_soft++;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr_seq(input logic [7:0] p, input int n);
        logic a;
        wq.delete();
        wdq.delete();
        i_master.start();
        i_master.wbyte(DEV_W, a);
        check({7'h0, a}, 8'h01);
        i_master.wbyte(p, a);
        check({7'h0, a}, 8'h01);
        for (int i = 0; i < n; i++)
            i_master.wbyte(8'(i), a);
        i_master.stop();
    endtask

    // Tail 0 ends with STOP, 1 sends one more byte first, 2 a Repeated START first
    task automatic gcall(input logic [7:0] cmd, input int tail, output logic [7:0] acks);
        acks = 8'h00;
        i_master.start();
        i_master.wbyte(IOX_GC_ADDR, acks[0]);
        i_master.wbyte(cmd, acks[1]);
        if (tail == 1)
            i_master.wbyte(IOX_GC_CMD, acks[2]);
        if (tail == 2)
            i_master.start();
        i_master.stop();
    endtask

    task automatic id_open(input logic [7:0] who, input logic split, output logic [7:0] acks);
        acks = 8'h00;
        i_master.start();
        i_master.wbyte(IOX_ID_WR, acks[2]);
        i_master.wbyte(who, acks[1]);
        if (split)
            i_master.stop();
        i_master.start();
        i_master.wbyte(IOX_ID_RD, acks[0]);
    endtask

    initial
    begin
        repeat (100000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        n_mismatch = 0;
        cmp_count  = 0;
        n_soft     = 0;
        n_rd       = 0;
        strap_hi   = 1'b1;
        strap_lo   = 1'b0;
        srst_i     = 1'b1;
        tp = '{8'h03, 8'h38, 8'h53, 8'h5C};
        te = '{'{7'h03, 7'h04, 7'h00}, '{7'h38, 7'h30, 7'h31}, '{7'h53, 7'h53, 7'h53}, '{7'h5C, 7'h54, 7'h55}};
        repeat (10) @(negedge clk_i);
        srst_i = 1'b0;
        @(negedge clk_i);
        check(ptr, 8'h00);
        wr_seq(8'h83, 2);
        check({1'b0, wq[0]}, 8'h03);
        check({1'b0, wq[1]}, 8'h04);
        check(wdq[1], 8'h01);
        check(ptr, 8'h85);
        wr_seq(8'h92, 3);
        check({1'b0, wq[2]}, 8'h30);
        wr_seq(8'hEE, 3);
        check({1'b0, wq[1]}, 8'h6F);
        check({1'b0, wq[2]}, 8'h00);
        wr_seq(8'h80, 83);
        check(8'(wq.size()), 8'h53);
        check({1'b0, wq[81]}, 8'h6E);
        check({1'b0, wq[82]}, 8'h00);
        check(wdq[82], 8'h52);
        for (int c = 0; c < 4; c++)
        begin
            wr_seq(tp[c], 3);
            for (int j = 0; j < 3; j++)
                check({1'b0, wq[j]}, {1'b0, te[c][j]});
        end
        wr_seq(8'h05, 0);
        i_master.start();
        i_master.wbyte(DEV_W | 8'h01, k[0]);
        check({7'h0, k[0]}, 8'h01);
        i_master.rbyte(1'b1, d);
        check(d, 8'h05 ^ 8'h5A);
        i_master.rbyte(1'b0, d);
        check(d, 8'h06 ^ 8'h5A);
        i_master.stop();
        check(8'(n_rd), 8'h02);
        wr_seq(8'h8A, 0);
        i_master.start();
        i_master.wbyte(8'h01, k[0]);
        i_master.stop();
        check({7'h0, k[0]}, 8'h00);
        gcall(8'h07, 0, k);
        check(k, 8'h01);
        gcall(IOX_GC_CMD, 1, k);
        check(k, 8'h03);
        gcall(IOX_GC_CMD, 2, k);
        check(k, 8'h03);
        check(8'(n_soft), 8'h00);
        check(ptr, 8'h8A);
        gcall(IOX_GC_CMD, 0, k);
        check(k, 8'h03);
        check(8'(n_soft), 8'h01);
        check(ptr, 8'h00);
        id_open(DEV_W | 8'h01, 1'b0, k);
        check(k, 8'h07);
        for (int j = 0; j < 5; j++)
        begin
            i_master.rbyte(j < 4, d);
            check(d, idw[23 - 8 * (j % 3) -: 8]);
        end
        i_master.stop();
        check(8'(n_rd), 8'h02);
        id_open(8'h46, 1'b0, k);
        i_master.stop();
        check(k, 8'h04);
        id_open(DEV_W, 1'b1, k);
        i_master.stop();
        check(k, 8'h06);
        wr_seq(8'h10, 1);
        check({1'b0, wq[0]}, 8'h10);
        strap_hi = 1'b0;
        strap_lo = 1'b1;
        k        = 8'h00;
        i_master.start();
        i_master.wbyte(DEV_W, k[1]);
        i_master.start();
        i_master.wbyte(8'h42, k[0]);
        i_master.stop();
        check(k, 8'h01);
        complete_run();
    end
endmodule
